// ===== shared/drv_ctrl_consts.vh
// constants for the output driver control register bank
// assumes a byte-wide register port already decoded to page and register offset
`ifndef DRV_CTRL_CONSTS_VH
`define DRV_CTRL_CONSTS_VH
`define PAGE_CTRL_OFS   8'h00
`define PAGE_ONE        8'h01
`define PAGE_THREE      8'h03
`define SPK_CTRL_OFS    8'h2a
`define RSV_ZERO_OFS    8'h2b
`define HP_CTRL_OFS     8'h2c
`define RSV_NOWR_OFS    8'h2d
`define BIAS_CTRL_OFS   8'h2e
`define TIMER_CFG_OFS   8'h10
`define TIMER_CFG_RST   8'h81
`define SPK_WMASK       8'h1c
`define HP_WMASK        8'hfe
`define BIAS_WMASK      8'h8b
`define ZERO_BYTE       8'h00
`define DIV_ZERO_COUNT  8'h80
`define DIV_ONE         8'h01
`define GAIN_SETTLE     8'h10
`define DEB_SUBTICKS    8'h08
`endif

// ===== src/debounce_tick.v
// debounce clock-enable generator for the headset short detector
// assumes a free running 1 MHz-class timebase tick from the owning block
`timescale 1ns/1ps
`include "drv_ctrl_consts.vh"
module debounce_tick (
  // clock and reset
  input  wire       ref_clk,
  input  wire       rst_b,
  // timebase and debounce code
  input  wire       baseTick,
  input  wire [2:0] debCode,
  // tick out, one per eighth of duration
  output reg        debTick
);
  reg  [6:0] cnt_reg;
  wire [6:0] periodLen;
  // code n>0 gives 2^(n-1) base ticks per debounce clock, code 0 none at all
  // seven bits so that code 7 reaches 64 ticks instead of wrapping to zero
  assign periodLen = (debCode == 3'h0) ? 7'h00 : (7'h01 << (debCode - 3'h1));
  // counting base ticks avoids a derived clock; the output is an enable
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      cnt_reg <= 7'h00;
      debTick <= 1'b0;
    end else begin
      debTick <= 1'b0;
      if (periodLen != 7'h00 && baseTick) begin
        if (cnt_reg + 7'h01 >= periodLen) begin
          cnt_reg <= 7'h00;
          debTick <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 7'h01;
        end
      end
    end
  end
endmodule // debounce_tick

// ===== src/output_driver_control_regs.v
// page one output driver control registers plus page three timer divider
// assumes a single-cycle byte register port decoded from the control bus
`timescale 1ns/1ps
`include "drv_ctrl_consts.vh"
module output_driver_control_regs #(
  parameter [7:0] OSC_DIV = 8'h08 // oscillator rises per timebase tick, near 1 MHz at nominal rate
) (
  // clock and reset
  input  wire       ref_clk,
  input  wire       rst_b,
  // register port
  input  wire       regWrite,
  input  wire       regRead,
  input  wire [7:0] regAddr,
  input  wire [7:0] regWdata,
  output reg  [7:0] regRdata,
  // analog side inputs
  input  wire       mclkIn,
  input  wire       oscTick,
  input  wire       headsetDetectEn,
  input  wire       headsetPresent,
  input  wire       spkGainSettled,
  // control outputs
  output reg  [1:0] spkGain,
  output reg        spkUnmute,
  output reg  [2:0] debounceCode,
  output reg  [1:0] dacPerfMode,
  output reg        leftHpPowerUp,
  output reg        rightHpPowerUp,
  output reg        swPowerDownEn,
  output reg  [1:0] micBiasLevel,
  output reg        micBiasPowerUp,
  output wire       debounceTick
);
  // register images
  reg  [7:0] page_reg;
  reg  [7:0] spk_reg;
  reg  [7:0] hp_reg;
  reg  [7:0] bias_reg;
  reg  [7:0] rsv_reg;
  reg  [7:0] tcfg_reg;
  // gain-applied tracking
  reg        gainDone_reg;
  reg  [7:0] settle_reg;
  // timebase dividers
  reg  [7:0] divCnt_reg;
  reg  [7:0] oscCnt_reg;
  reg        baseTick_reg;
  // pin synchronisers and last agreed levels
  reg  [2:0] mclkSync_reg;
  reg        mclkSeen_reg;
  reg  [2:0] oscSync_reg;
  reg        oscSeen_reg;
  // decode and edge helpers
  wire [7:0] divLimit;
  wire       onP1;
  wire       onP3;
  wire       mclkRise;
  wire       oscRise;
  wire       srcTick;

  // page decode; the page register itself answers on every page
  assign onP1 = (page_reg == `PAGE_ONE);
  assign onP3 = (page_reg == `PAGE_THREE);
  // divide code zero stands for 128
  assign divLimit = (tcfg_reg[6:0] == 7'h00) ? `DIV_ZERO_COUNT : {1'b0, tcfg_reg[6:0]};

  // pin inputs pass three flops; edge is taken when second and third agree on a change
  // a glitch caught by the first flop alone never counts as an edge
  // only the second flop reads the first, so metastability stays in one place
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      mclkSync_reg <= 3'h0;
      oscSync_reg  <= 3'h0;
      mclkSeen_reg <= 1'b0;
      oscSeen_reg  <= 1'b0;
    end else begin
      mclkSync_reg <= {mclkSync_reg[1:0], mclkIn};
      oscSync_reg  <= {oscSync_reg[1:0], oscTick};
      if (mclkSync_reg[2] == mclkSync_reg[1]) mclkSeen_reg <= mclkSync_reg[2];
      if (oscSync_reg[2] == oscSync_reg[1]) oscSeen_reg <= oscSync_reg[2];
    end
  end
  assign mclkRise = (mclkSync_reg[2] == mclkSync_reg[1]) && mclkSync_reg[2] && !mclkSeen_reg;
  assign oscRise  = (oscSync_reg[2] == oscSync_reg[1]) && oscSync_reg[2] && !oscSeen_reg;
  // bit7 set picks external master clock, else internal oscillator
  assign srcTick = tcfg_reg[7] ? mclkRise : oscRise;

  // timebase: master clock divided to 1 MHz, or oscillator prescaled
  // counters give a tick enable rather than a derived clock, so everything stays on ref_clk
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      divCnt_reg   <= `ZERO_BYTE;
      oscCnt_reg   <= `ZERO_BYTE;
      baseTick_reg <= 1'b0;
    end else begin
      baseTick_reg <= 1'b0;
      if (srcTick && tcfg_reg[7]) begin
        // master clock path: one tick per divider count of agreed rises
        if (divCnt_reg + `DIV_ONE >= divLimit) begin
          divCnt_reg   <= `ZERO_BYTE;
          baseTick_reg <= 1'b1;
        end else begin
          divCnt_reg <= divCnt_reg + `DIV_ONE;
        end
      end else if (srcTick) begin
        // oscillator path: prescaled to near 1 MHz at nominal rate; durations scale with its rate
        if (oscCnt_reg + `DIV_ONE >= OSC_DIV) begin
          oscCnt_reg   <= `ZERO_BYTE;
          baseTick_reg <= 1'b1;
        end else begin
          oscCnt_reg <= oscCnt_reg + `DIV_ONE;
        end
      end
    end
  end

  // debounce clock enable stepped by the shared timebase
  debounce_tick u_deb (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .baseTick (baseTick_reg),
    .debCode  (hp_reg[7:5]),
    .debTick  (debounceTick)
  );

  // register writes; reserved bits of 0x2a, 0x2c and 0x2e masked so they always hold zero
  // 0x2b has no image at all: writes to it fall through and are lost
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      page_reg <= `ZERO_BYTE;
      spk_reg  <= `ZERO_BYTE;
      hp_reg   <= `ZERO_BYTE;
      bias_reg <= `ZERO_BYTE;
      rsv_reg  <= `ZERO_BYTE;
      tcfg_reg <= `TIMER_CFG_RST;
    end else if (regWrite) begin
      // the page register answers at offset zero whatever page is selected
      if (regAddr == `PAGE_CTRL_OFS) begin
        page_reg <= regWdata;
      end else if (onP1 && regAddr == `SPK_CTRL_OFS) begin
        spk_reg <= regWdata & `SPK_WMASK;
      end else if (onP1 && regAddr == `HP_CTRL_OFS) begin
        // code 10 for performance is refused and old value kept
        if (regWdata[4:3] == 2'h2) begin
          hp_reg <= {regWdata[7:5], hp_reg[4:3], regWdata[2:1], 1'b0};
        end else begin
          hp_reg <= regWdata & `HP_WMASK;
        end
      end else if (onP1 && regAddr == `RSV_NOWR_OFS) begin
        // plain storage; software never writes it, so its content has no meaning
        rsv_reg <= regWdata;
      end else if (onP1 && regAddr == `BIAS_CTRL_OFS) begin
        bias_reg <= regWdata & `BIAS_WMASK;
      end else if (onP3 && regAddr == `TIMER_CFG_OFS) begin
        // source and divider take effect from the next agreed clock rise
        tcfg_reg <= regWdata;
      end
    end
  end

  // gain applied flag: clears on a gain change, sets after ramp or analog report
  // a write that keeps the gain leaves the flag alone, nothing new is pending
  // the clear outranks the report, which still refers to the gain being replaced
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      gainDone_reg <= 1'b0;
      settle_reg   <= `ZERO_BYTE;
    end else if (regWrite && onP1 && regAddr == `SPK_CTRL_OFS && regWdata[4:3] != spk_reg[4:3]) begin
      gainDone_reg <= 1'b0;
      settle_reg   <= `ZERO_BYTE;
    end else if (!gainDone_reg) begin
      if (spkGainSettled || settle_reg == `GAIN_SETTLE) gainDone_reg <= 1'b1;
      else settle_reg <= settle_reg + `DIV_ONE;
    end
  end

  // read data, registered one cycle after the read strobe
  // unmapped offsets read zero so a wrong page never returns stale data
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      regRdata <= `ZERO_BYTE;
    end else if (regRead) begin
      if (regAddr == `PAGE_CTRL_OFS) regRdata <= page_reg;
      else if (onP1 && regAddr == `SPK_CTRL_OFS) regRdata <= {spk_reg[7:1], gainDone_reg};
      else if (onP1 && regAddr == `RSV_ZERO_OFS) regRdata <= `ZERO_BYTE;
      else if (onP1 && regAddr == `HP_CTRL_OFS) regRdata <= hp_reg;
      else if (onP1 && regAddr == `RSV_NOWR_OFS) regRdata <= rsv_reg;
      else if (onP1 && regAddr == `BIAS_CTRL_OFS) regRdata <= bias_reg;
      else if (onP3 && regAddr == `TIMER_CFG_OFS) regRdata <= tcfg_reg;
      else regRdata <= `ZERO_BYTE;
    end
  end

  // decoded controls, all from flops
  // one cycle behind the images, so the analog side never sees a half-written byte
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      spkGain        <= 2'h0;
      spkUnmute      <= 1'b0;
      debounceCode   <= 3'h0;
      dacPerfMode    <= 2'h0;
      leftHpPowerUp  <= 1'b0;
      rightHpPowerUp <= 1'b0;
      swPowerDownEn  <= 1'b0;
      micBiasLevel   <= 2'h0;
      micBiasPowerUp <= 1'b0;
    end else begin
      spkGain        <= spk_reg[4:3];
      spkUnmute      <= spk_reg[2];
      debounceCode   <= hp_reg[7:5];
      dacPerfMode    <= hp_reg[4:3];
      leftHpPowerUp  <= hp_reg[2];
      rightHpPowerUp <= hp_reg[1];
      swPowerDownEn  <= bias_reg[7];
      micBiasLevel   <= bias_reg[1:0];
      // bias gated off when detection on and no headset, unless forced
      micBiasPowerUp <= (bias_reg[1:0] != 2'h0) &&
                        (bias_reg[3] || !headsetDetectEn || headsetPresent);
    end
  end
endmodule // output_driver_control_regs

// ===== tb/host_model.sv
// host side of the register port: single-strobe writes and reads
// assumes the bank answers reads one cycle after the strobe
`timescale 1ns/1ps
module host_model (
  input  wire       ref_clk,
  output reg        regWrite,
  output reg        regRead,
  output reg  [7:0] regAddr,
  output reg  [7:0] regWdata,
  input  wire [7:0] regRdata
);
  initial begin
    {regWrite, regRead, regAddr, regWdata} = 18'h0;
  end
  // released data is inverted so a stale value never reads as valid; 0x2d is never written
  task wr(input [7:0] a, input [7:0] d);
    @(posedge ref_clk) #1 {regWrite, regAddr, regWdata} = {1'b1, a, d};
    @(posedge ref_clk) #1 {regWrite, regWdata} = {1'b0, ~d};
  endtask
  task rd(input [7:0] a, output [7:0] d);
    @(posedge ref_clk) #1 {regRead, regAddr} = {1'b1, a};
    @(posedge ref_clk) #1 regRead = 1'b0;
    d = regRdata;
  endtask
endmodule // host_model

// ===== tb/odc_assertions.sv
// timing checks for the output driver control bank
// assumes it is bound to the bank's top module ports
`timescale 1ns/1ps
module odc_assertions (
  // clock and reset
  input wire       ref_clk,
  input wire       rst_b,
  // register port
  input wire       regWrite,
  input wire       regRead,
  input wire [7:0] regAddr,
  input wire [7:0] regWdata,
  input wire [7:0] regRdata,
  // control outputs
  input wire [1:0] spkGain,
  input wire [1:0] dacPerfMode,
  input wire [1:0] micBiasLevel,
  input wire       spkUnmute,
  input wire       leftHpPowerUp,
  input wire       swPowerDownEn,
  input wire       micBiasPowerUp
);
  // page shadow and write data two cycles back, matching the write latency
  reg [7:0] pageReg, wd1, wd2;
  always @(posedge ref_clk) begin
    pageReg <= !rst_b ? 8'h00 : (regWrite && regAddr == 8'h00) ? regWdata : pageReg;
    wd1     <= regWdata;
    wd2     <= wd1;
  end
  wire w1 = regWrite && pageReg == 8'h01;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  chk_spk_gain: assert property (w1 && regAddr == 8'h2a |-> ##2 spkGain == wd2[4:3])
    else $error("speaker gain wrong");
  chk_spk_mute: assert property (w1 && regAddr == 8'h2a |-> ##2 spkUnmute == wd2[2])
    else $error("speaker mute wrong");
  chk_hp_left: assert property (w1 && regAddr == 8'h2c |-> ##2 leftHpPowerUp == wd2[2])
    else $error("left driver power wrong");
  chk_perf_hold: assert property (w1 && regAddr == 8'h2c && regWdata[4:3] == 2'h2 |=> ##1 $stable(dacPerfMode))
    else $error("reserved mode taken");
  chk_swpd_set: assert property (w1 && regAddr == 8'h2e |-> ##2 swPowerDownEn == wd2[7])
    else $error("power-down enable wrong");
  chk_bias_level: assert property (w1 && regAddr == 8'h2e |-> ##2 micBiasLevel == wd2[1:0])
    else $error("bias level wrong");
  chk_bias_off: assert property (micBiasLevel == 2'h0 [*2] |-> !micBiasPowerUp)
    else $error("bias up while off");
  chk_rsv_zero: assert property (regRead && pageReg == 8'h01 && regAddr == 8'h2b |=> regRdata == 8'h00)
    else $error("reserved not zero");
  cover property (w1 && regAddr == 8'h2a);
  cover property (micBiasPowerUp);
  cover property (w1 && regAddr == 8'h2c && regWdata[4:3] == 2'h2);
endmodule // odc_assertions
bind output_driver_control_regs odc_assertions chk (.ref_clk(ref_clk), .rst_b(rst_b), .regWrite(regWrite),
  .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .spkGain(spkGain),
  .dacPerfMode(dacPerfMode), .micBiasLevel(micBiasLevel), .spkUnmute(spkUnmute), .leftHpPowerUp(leftHpPowerUp),
  .swPowerDownEn(swPowerDownEn), .micBiasPowerUp(micBiasPowerUp));

// ===== tb/output_driver_control_regs_tb_top.sv
// self-checking bench for the output driver control bank
// assumes master clock source with divider one after reset
`timescale 1ns/1ps
module output_driver_control_regs_tb_top;
  reg        ref_clk, rst_b, mclkIn, osc, setl, hsEn, hsIn;
  reg [2:0]  code;
  wire       regWrite, regRead, mute, left, right, swPd, micUp, tick;
  wire [7:0] regAddr, regWdata, regRdata;
  wire [1:0] gain, perf, level;
  wire [2:0] deb;
  integer    error_cnt = 0, checked = 0, i, n;
  reg [31:0] seed = 32'h00011738;
  reg [7:0]  d, speaker_driver, hpM, bias, cfg, expN;
  output_driver_control_regs uut (.ref_clk(ref_clk), .rst_b(rst_b), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .mclkIn(mclkIn), .oscTick(osc),
    .headsetDetectEn(hsEn), .headsetPresent(hsIn), .spkGainSettled(setl), .spkGain(gain), .spkUnmute(mute),
    .debounceCode(deb), .dacPerfMode(perf), .leftHpPowerUp(left), .rightHpPowerUp(right),
    .swPowerDownEn(swPd), .micBiasLevel(level), .micBiasPowerUp(micUp), .debounceTick(tick));
  host_model host (.ref_clk(ref_clk), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // 40 ns master clock: one 1 MHz-class timebase tick every 8 cycles
  always #20 mclkIn = ~mclkIn;
  // 20 ns oscillator: one rise every 4 cycles, eight rises per timebase tick
  always #10 osc = ~osc;
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task cmp(input [7:0] seen, input [7:0] exp, input string nm);
    checked = checked + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task complete_run;
    if (error_cnt == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // watchdog, well beyond the expected run
  initial begin
    #200000 error_cnt = error_cnt + 1;
    complete_run;
  end
  initial begin
    {rst_b, mclkIn, osc, hsEn, hsIn, setl} = 6'h00;
    repeat (4) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    host.wr(8'h00, 8'h01);
    host.rd(8'h2a, d); cmp(d, 8'h00, "spk reset");
    host.rd(8'h2c, d); cmp(d, 8'h00, "hp reset");
    host.rd(8'h2e, d); cmp(d, 8'h00, "bias reset");
    // let the reset-time gain settle finish so an unchanged gain reads as applied
    repeat (20) @(posedge ref_clk);
    {speaker_driver, hpM} = 16'h0;
    // random traffic against the bench's own register picture
    for (i = 0; i < 24; i = i + 1) begin
      seed = lfsr(seed);
      d = seed[7:0] & 8'h1c;
      n = (d[4:3] == speaker_driver[4:3]);
      speaker_driver = d;
      host.wr(8'h2a, d);
      host.rd(8'h2a, d); cmp(d, speaker_driver | n[7:0], "spk read");
      cmp({gain, mute}, speaker_driver[4:2], "spk out");
      d = seed[15:8] & 8'hfe;
      host.wr(8'h2c, d);
      hpM = {d[7:5], d[4:3] == 2'h2 ? hpM[4:3] : d[4:3], d[2:0]};
      host.rd(8'h2c, d); cmp(d, hpM, "hp read");
      cmp({deb, perf, left, right}, hpM[7:1], "hp out");
      bias = seed[23:16] & 8'h8b;
      {hsEn, hsIn} = seed[25:24];
      host.wr(8'h2e, bias);
      host.rd(8'h2e, d); cmp(d, bias, "bias read");
      cmp({swPd, level}, {bias[7], bias[1:0]}, "bias out");
      cmp(micUp, bias[1:0] != 2'h0 && (bias[3] || !hsEn || hsIn), "bias power");
      repeat (20) @(posedge ref_clk);
      host.rd(8'h2a, d); cmp(d[0], 1'b1, "gain done");
    end
    host.wr(8'h2b, 8'h5a);
    host.rd(8'h2b, d); cmp(d, 8'h00, "rsv zero");
    // analog report of an applied gain beats the settle count
    setl = 1'b1;
    host.wr(8'h2a, speaker_driver ^ 8'h08);
    host.rd(8'h2a, d); cmp(d[0], 1'b1, "gain settled");
    setl = 1'b0;
    host.wr(8'h00, 8'h03);
    host.rd(8'h10, d); cmp(d, 8'h81, "timer cfg");
    // pulses per 1024 cycles: mclk rise every 8 cycles over div 1 or 2, oscillator rise every 4 over eight
    for (i = 0; i < 5; i = i + 1) begin
      case (i)
        0: {cfg, code, expN} = {8'h81, 3'h3, 8'h20}; // 4 ticks of 8 cycles
        1: {cfg, code, expN} = {8'h82, 3'h3, 8'h10}; // 4 ticks of 16 cycles
        2: {cfg, code, expN} = {8'h00, 3'h1, 8'h20}; // 1 tick of 8 oscillator rises
        3: {cfg, code, expN} = {8'h81, 3'h7, 8'h02}; // 64 ticks of 8 cycles
        default: {cfg, code, expN} = {8'h81, 3'h0, 8'h00}; // code 0 gives none
      endcase
      host.wr(8'h00, 8'h03);
      host.wr(8'h10, cfg);
      host.wr(8'h00, 8'h01);
      host.wr(8'h2c, {code, 5'h00});
      repeat (64) @(posedge ref_clk);
      n = 0;
      repeat (1024) @(posedge ref_clk) #1 n = n + tick;
      cmp(n[7:0], expN, "deb rate");
    end
    complete_run;
  end
endmodule // output_driver_control_regs_tb_top
